// ### common/spmt_pkg.sv
package spmt_pkg;
  localparam int NUM_CS = 8;
  localparam int ADDR_W = 26;
  // register map, byte offsets inside one chip select block
  localparam logic [7:0] OFF_SETUP = 8'h00;
  localparam logic [7:0] OFF_PULSE = 8'h04;
  localparam logic [7:0] OFF_CYCLE = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0c;
  localparam logic [7:0] CS_STRIDE = 8'h10;
  localparam logic [7:0] MAP_END = 8'h80;
  // reset values
  localparam logic [31:0] RST_SETUP = 32'h00000000;
  localparam logic [31:0] RST_PULSE = 32'h01010101;
  localparam logic [31:0] RST_CYCLE = 32'h00030003;
  localparam logic [31:0] RST_MODE = 32'h10001000;
  // writable bits, the rest read zero
  localparam logic [31:0] MASK_SETUP = 32'h3f3f3f3f;
  localparam logic [31:0] MASK_PULSE = 32'h7f7f7f7f;
  localparam logic [31:0] MASK_CYCLE = 32'h01ff01ff;
  localparam logic [31:0] MASK_MODE = 32'h311f3133;
  // setup and pulse field positions
  localparam int F_WE = 0;
  localparam int F_CS_WR = 8;
  localparam int F_RD = 16;
  localparam int F_CS_RD = 24;
  localparam int SETUP_W = 6;
  localparam int PULSE_W = 7;
  // cycle field positions
  localparam int F_WR_CYCLE = 0;
  localparam int F_RD_CYCLE = 16;
  localparam int CYCLE_W = 9;
  // mode field positions
  localparam int F_BAT = 8;
  localparam int F_DBW = 12;
  localparam int F_PAGE_MODE_ENABLE = 24;
  localparam int F_PS = 28;
  localparam logic [1:0] DBW_16 = 2'h1;
  localparam logic [1:0] DBW_32 = 2'h2;
  localparam logic [25:0] PAGE_MIN = 26'h0000004;
  localparam logic [25:0] IGN_16 = 26'h0000001;
  localparam logic [25:0] IGN_32 = 26'h0000003;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_STD = 5'h02,
    ST_PAGE = 5'h04,
    ST_PGOPEN = 5'h08,
    ST_GAP = 5'h10
  } spmt_state_type;

  typedef struct packed {
    logic [2:0] cs;
    logic [25:0] addr;
    logic write;
    logic [3:0] be;
    logic [31:0] wdata;
  } spmt_req_type;
endpackage : spmt_pkg

// ### verilog/spmt_field_len.sv
`timescale 1ns/1ps
// field to cycle count: (top bits << sh) + low bits
module spmt_field_len #(
  parameter int FW = 6,
  parameter int LW = 5,
  parameter int SH = 7
) (
  // field
  input wire logic [FW-1:0] field,
  // length in cycles
  output logic [9:0] len
);
  assign len = (10'(field[FW-1:LW]) << SH) + 10'(field[LW-1:0]);
endmodule : spmt_field_len

// ### verilog/spmt_controller.sv
`timescale 1ns/1ps
module spmt_controller (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // access requests
  input wire logic req_valid,
  input wire spmt_pkg::spmt_req_type req,
  output logic req_ready,
  output logic rd_valid,
  output logic [31:0] rd_data,
  // memory pins
  output logic [7:0] chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [3:0] byte_select_n,
  output logic [25:0] mem_addr,
  output logic [31:0] mem_data_out,
  output logic mem_data_oe,
  input wire logic [31:0] mem_data_in
);
  ////////////////////////////////////////////////////////////////////////
  // register bank
  logic [7:0][31:0] stg_setup_q;
  logic [7:0][31:0] stg_pulse_q;
  logic [7:0][31:0] stg_cycle_q;
  logic [7:0][31:0] act_setup_q;
  logic [7:0][31:0] act_pulse_q;
  logic [7:0][31:0] act_cycle_q;
  logic [7:0][31:0] mode_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;

  wire apb_wr = psel & penable & pwrite;
  wire mapped = (paddr < spmt_pkg::MAP_END) & (paddr[1:0] == 2'h0);
  wire [2:0] reg_cs = paddr[6:4];
  wire [3:0] reg_off = paddr[3:0];
  wire wr_ok = apb_wr & mapped;
  wire wr_setup = wr_ok & (reg_off == spmt_pkg::OFF_SETUP[3:0]);
  wire wr_pulse = wr_ok & (reg_off == spmt_pkg::OFF_PULSE[3:0]);
  wire wr_cycle = wr_ok & (reg_off == spmt_pkg::OFF_CYCLE[3:0]);
  wire wr_mode = wr_ok & (reg_off == spmt_pkg::OFF_MODE[3:0]);

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_q;

  always_comb begin
    case (reg_off)
      spmt_pkg::OFF_SETUP[3:0]: rd_mux = stg_setup_q[reg_cs];
      spmt_pkg::OFF_PULSE[3:0]: rd_mux = stg_pulse_q[reg_cs];
      spmt_pkg::OFF_CYCLE[3:0]: rd_mux = stg_cycle_q[reg_cs];
      spmt_pkg::OFF_MODE[3:0]: rd_mux = mode_q[reg_cs];
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stg_setup_q <= {8{spmt_pkg::RST_SETUP}};
      stg_pulse_q <= {8{spmt_pkg::RST_PULSE}};
      stg_cycle_q <= {8{spmt_pkg::RST_CYCLE}};
      act_setup_q <= {8{spmt_pkg::RST_SETUP}};
      act_pulse_q <= {8{spmt_pkg::RST_PULSE}};
      act_cycle_q <= {8{spmt_pkg::RST_CYCLE}};
      mode_q <= {8{spmt_pkg::RST_MODE}};
      prdata_q <= 32'h00000000;
    end else begin
      if (wr_setup) stg_setup_q[reg_cs] <= pwdata & spmt_pkg::MASK_SETUP;
      if (wr_pulse) stg_pulse_q[reg_cs] <= pwdata & spmt_pkg::MASK_PULSE;
      if (wr_cycle) stg_cycle_q[reg_cs] <= pwdata & spmt_pkg::MASK_CYCLE;
      if (wr_mode) begin
        mode_q[reg_cs] <= pwdata & spmt_pkg::MASK_MODE;
        act_setup_q <= stg_setup_q;
        act_pulse_q <= stg_pulse_q;
        act_cycle_q <= stg_cycle_q;
      end
      if (psel && !penable && !pwrite) begin
        prdata_q <= mapped ? rd_mux : 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timing of the access in progress
  spmt_pkg::spmt_state_type state_q;
  spmt_pkg::spmt_state_type state_d;
  logic [2:0] cur_cs_q;
  logic [25:0] cur_addr_q;
  logic cur_wr_q;
  logic [3:0] cur_be_q;
  logic first_q;
  logic [9:0] cnt_q;
  logic [9:0] st_set_len;
  logic [9:0] cs_set_len;
  logic [9:0] st_pul_len;
  logic [9:0] cs_pul_len;
  logic [9:0] cyc_len;

  wire [31:0] c_set = act_setup_q[cur_cs_q];
  wire [31:0] c_pul = act_pulse_q[cur_cs_q];
  wire [31:0] c_cyc = act_cycle_q[cur_cs_q];
  wire [31:0] c_mode = mode_q[cur_cs_q];
  // direction picks write or read fields
  wire [5:0] st_set_f = cur_wr_q ? c_set[spmt_pkg::F_WE +: 6]
                                 : c_set[spmt_pkg::F_RD +: 6];
  wire [5:0] cs_set_f = cur_wr_q ? c_set[spmt_pkg::F_CS_WR +: 6]
                                 : c_set[spmt_pkg::F_CS_RD +: 6];
  wire [6:0] st_pul_f = cur_wr_q ? c_pul[spmt_pkg::F_WE +: 7]
                                 : c_pul[spmt_pkg::F_RD +: 7];
  wire [6:0] cs_pul_f = cur_wr_q ? c_pul[spmt_pkg::F_CS_WR +: 7]
                                 : c_pul[spmt_pkg::F_CS_RD +: 7];
  wire [8:0] cyc_f = cur_wr_q ? c_cyc[spmt_pkg::F_WR_CYCLE +: 9]
                              : c_cyc[spmt_pkg::F_RD_CYCLE +: 9];

  spmt_field_len #(.FW(6), .LW(5), .SH(7)) u_st_set (
    .field(st_set_f),
    .len(st_set_len)
  );
  spmt_field_len #(.FW(6), .LW(5), .SH(7)) u_cs_set (
    .field(cs_set_f),
    .len(cs_set_len)
  );
  spmt_field_len #(.FW(7), .LW(6), .SH(8)) u_st_pul (
    .field(st_pul_f),
    .len(st_pul_len)
  );
  spmt_field_len #(.FW(7), .LW(6), .SH(8)) u_cs_pul (
    .field(cs_pul_f),
    .len(cs_pul_len)
  );
  spmt_field_len #(.FW(9), .LW(7), .SH(8)) u_cyc (
    .field(cyc_f),
    .len(cyc_len)
  );

  ////////////////////////////////////////////////////////////////////////
  // page decision for the incoming request
  wire [31:0] r_mode = mode_q[req.cs];
  wire req_page_rd = r_mode[spmt_pkg::F_PAGE_MODE_ENABLE] & ~req.write;
  wire [1:0] r_ps = r_mode[spmt_pkg::F_PS +: 2];
  wire [1:0] r_dbw = r_mode[spmt_pkg::F_DBW +: 2];
  // in-page offset mask, page aligned to its size
  wire [25:0] pg_low = 26'((spmt_pkg::PAGE_MIN << r_ps) - 26'h1);
  wire same_page = ((req.addr ^ cur_addr_q) & ~pg_low) == 26'h0;
  wire [25:0] ign = (r_dbw == spmt_pkg::DBW_16) ? spmt_pkg::IGN_16 :
                    (r_dbw == spmt_pkg::DBW_32) ? spmt_pkg::IGN_32 : 26'h0;
  wire page_hit = (state_q == spmt_pkg::ST_PGOPEN) & req_page_rd &
                  (req.cs == cur_cs_q) & same_page;
  assign req_ready = (state_q == spmt_pkg::ST_IDLE) | page_hit;
  wire take = req_valid & req_ready;

  // first access takes the chip select pulse length, later ones the strobe pulse length, no coherency check
  wire [9:0] pg_len = first_q ? cs_pul_len : st_pul_len;
  wire [9:0] pg_last = (pg_len == 10'h0) ? 10'h0 : pg_len - 10'h1;
  wire [9:0] cyc_last = (cyc_len == 10'h0) ? 10'h0 : cyc_len - 10'h1;
  wire std_end = (state_q == spmt_pkg::ST_STD) & (cnt_q == cyc_last);
  wire pg_end = (state_q == spmt_pkg::ST_PAGE) & (cnt_q == pg_last);
  wire acc_end = std_end | pg_end;

  always_comb begin
    state_d = state_q;
    case (state_q)
      spmt_pkg::ST_IDLE: begin
        if (take) begin
          state_d = req_page_rd ? spmt_pkg::ST_PAGE : spmt_pkg::ST_STD;
        end
      end
      spmt_pkg::ST_STD: begin
        if (acc_end) state_d = spmt_pkg::ST_IDLE;
      end
      spmt_pkg::ST_PAGE: begin
        if (acc_end) state_d = spmt_pkg::ST_PGOPEN;
      end
      spmt_pkg::ST_PGOPEN: begin
        if (take) begin
          state_d = spmt_pkg::ST_PAGE;
        end else if (req_valid) begin
          state_d = spmt_pkg::ST_GAP;
        end
      end
      spmt_pkg::ST_GAP: state_d = spmt_pkg::ST_IDLE;
      default: state_d = spmt_pkg::ST_IDLE;
    endcase
  end

  wire counting = (state_q == spmt_pkg::ST_STD) |
                  (state_q == spmt_pkg::ST_PAGE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= spmt_pkg::ST_IDLE;
      cnt_q <= 10'h0;
      first_q <= 1'b0;
      cur_cs_q <= 3'h0;
      cur_addr_q <= 26'h0;
      cur_wr_q <= 1'b0;
      cur_be_q <= 4'h0;
    end else begin
      state_q <= state_d;
      if (take) begin
        cnt_q <= 10'h0;
        first_q <= (state_q == spmt_pkg::ST_IDLE);
        cur_cs_q <= req.cs;
        cur_addr_q <= req.addr;
        cur_wr_q <= req.write;
        cur_be_q <= req.be;
      end else if (counting && !acc_end) begin
        cnt_q <= cnt_q + 10'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin waveforms, registered
  wire [10:0] cs_stop = 11'(cs_set_len) + 11'(cs_pul_len);
  wire [10:0] st_stop = 11'(st_set_len) + 11'(st_pul_len);
  wire std_on = state_q == spmt_pkg::ST_STD;
  wire cs_win = ({1'b0, cnt_q} >= {1'b0, cs_set_len}) &
                ({1'b0, cnt_q} < cs_stop);
  wire st_win = ({1'b0, cnt_q} >= {1'b0, st_set_len}) &
                ({1'b0, cnt_q} < st_stop);
  // page mode holds both low regardless of setup and hold
  wire pg_on = (state_q == spmt_pkg::ST_PAGE) |
               (state_q == spmt_pkg::ST_PGOPEN);
  wire cs_act = (std_on & cs_win) | pg_on;
  wire rd_act = (std_on & st_win & ~cur_wr_q) | pg_on;
  wire wr_act = std_on & st_win & cur_wr_q;
  wire use_bsel = ~c_mode[spmt_pkg::F_BAT] &
                  (c_mode[spmt_pkg::F_DBW +: 2] != 2'h0);
  logic [31:0] din_meta_q;
  logic [31:0] din_sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_select_n <= 8'hff;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      byte_select_n <= 4'hf;
      mem_addr <= 26'h0;
      mem_data_out <= 32'h0;
      mem_data_oe <= 1'b0;
      din_meta_q <= 32'h0;
      din_sync_q <= 32'h0;
      rd_valid <= 1'b0;
      rd_data <= 32'h0;
    end else begin
      chip_select_n <= cs_act ? ~(8'h01 << cur_cs_q) : 8'hff;
      read_strobe_n <= ~rd_act;
      write_strobe_n <= ~wr_act;
      byte_select_n <= (cs_act && use_bsel) ? ~cur_be_q : 4'hf;
      if (take) begin
        mem_addr <= req.addr & ~ign;
        mem_data_out <= req.wdata;
      end
      mem_data_oe <= std_on & cur_wr_q;
      din_meta_q <= mem_data_in;
      din_sync_q <= din_meta_q;
      rd_valid <= acc_end & ~cur_wr_q;
      if (acc_end && !cur_wr_q) rd_data <= din_sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [9:0] pg_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_cnt_q <= 10'h0;
    end else if (state_q == spmt_pkg::ST_PAGE && !acc_end) begin
      pg_cnt_q <= pg_cnt_q + 10'h1;
    end else begin
      pg_cnt_q <= 10'h0;
    end
  end
  wire [9:0] exp_first = (10'(c_pul[spmt_pkg::F_CS_RD + 6]) << 8) +
                         10'(c_pul[spmt_pkg::F_CS_RD +: 6]);

  page_rd_low_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q == spmt_pkg::ST_PAGE) |=>
      (read_strobe_n == 1'b0 && chip_select_n != 8'hff))
    else $error("page read strobes not held low");

  page_first_len_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pg_end && first_q && exp_first != 10'h0) |->
      (pg_cnt_q + 10'h1 == exp_first))
    else $error("first page access length wrong");

  page_hit_short_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q == spmt_pkg::ST_PGOPEN && req_valid && page_hit) |=>
      (state_q == spmt_pkg::ST_PAGE && !first_q))
    else $error("page hit did not take short access");

  page_break_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q == spmt_pkg::ST_PGOPEN && req_valid && !page_hit) |=>
      (state_q == spmt_pkg::ST_GAP) ##1 (state_q == spmt_pkg::ST_IDLE))
    else $error("page break not taken");

  gap_cs_high_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q == spmt_pkg::ST_GAP) |=> (chip_select_n == 8'hff))
    else $error("chip select not released between accesses");

  mode_commit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_mode |=> (act_pulse_q == $past(stg_pulse_q) &&
                 act_setup_q == $past(stg_setup_q)))
    else $error("mode write did not commit timings");

  no_commit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_setup || wr_pulse) |=> $stable(act_pulse_q) && $stable(act_setup_q))
    else $error("timing applied before mode write");

  wr_no_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q == spmt_pkg::ST_STD && cur_wr_q) |=> (read_strobe_n == 1'b1))
    else $error("read strobe active during write");
endmodule : spmt_controller

// ### verification/spmt_mem_model.sv
`timescale 1ns/1ps
module spmt_mem_model (
  // memory pins
  input wire logic [7:0] chip_select_n,
  input wire logic read_strobe_n,
  input wire logic [25:0] mem_addr,
  // data back to the controller
  output logic [31:0] mem_data_in
);
  logic [31:0] last_q = 32'h0;
  wire sel = !(&chip_select_n) && !read_strobe_n;
  wire [31:0] word = {~mem_addr[5:0], mem_addr};
  // released bus shows the inverse of the last word
  always @* if (sel) last_q = word;
  assign mem_data_in = sel ? word : ~last_q;
endmodule : spmt_mem_model

// ### verification/test_static_mem_page_mode_timing.sv
`timescale 1ns/1ps
module test_static_mem_page_mode_timing;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic req_valid = 1'b0;
  spmt_pkg::spmt_req_type req = '0;
  logic [31:0] prdata, rd_data, mem_data_out, mem_data_in, rv, wd;
  logic pready, pslverr, req_ready, rd_valid, read_strobe_n, ev;
  logic write_strobe_n, mem_data_oe;
  logic [7:0] chip_select_n;
  logic [3:0] byte_select_n, bs;
  logic [25:0] mem_addr, ma, a;
  int error_cnt = 0;
  int n_compared = 0;
  int lat, lo1, nlo, dif, sz, wlo, noe;
  ////////////////////////////////////////////////////////////////////////
  spmt_controller DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .byte_select_n(byte_select_n), .mem_addr(mem_addr),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
    .mem_data_in(mem_data_in));
  spmt_mem_model mem (.chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .mem_addr(mem_addr),
    .mem_data_in(mem_data_in));
  initial forever #12.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic hang;
    error_cnt++;
    $display("MISMATCH wait expected done seen timeout");
    give_verdict();
  endtask : hang
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [7:0] ra(input int c, input logic [7:0] o);
    return 8'(c * 16) + o;
  endfunction : ra
  function automatic logic [31:0] md(input logic pm, input logic [1:0] ps,
    input logic [1:0] dw, input logic bt);
    return {2'h0, ps, 3'h0, pm, 10'h0, dw, 3'h0, bt, 8'h0};
  endfunction : md
  ////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
      if (i > 50) hang();
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask : wr
  task automatic rc(input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    chk("register", e, rv);
  endtask : rc
  task automatic acc(input logic w, input logic [2:0] c,
    input logic [25:0] ad);
    int i;
    @(posedge pclk);
    req_valid <= 1'b1;
    req <= '{cs: c, addr: ad, write: w, be: 4'h5, wdata: 32'h0badf00d};
    i = 0;
    do begin
      @(posedge pclk);
      i++;
      if (i > 50) hang();
    end while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    lat = 0;
    lo1 = 0;
    nlo = 0;
    dif = 0;
    wlo = 0;
    noe = 0;
    wd = 32'h0;
    for (int k = 1; k < 600 && lat == 0; k++) begin
      @(posedge pclk);
      #1;
      if (write_strobe_n === 1'b0) wlo++;
      if (mem_data_oe === 1'b1) noe++;
      if (mem_data_oe === 1'b1) wd = mem_data_out;
      if (chip_select_n[c] === 1'b0) nlo++;
      if (chip_select_n[c] === 1'b0 && lo1 == 0) lo1 = k;
      if (chip_select_n[c] !== read_strobe_n) dif++;
      if (w ? req_ready === 1'b1 : rd_valid === 1'b1) begin
        lat = k;
        rv = rd_data;
        ma = mem_addr;
        bs = byte_select_n;
      end
    end
    if (lat == 0) hang();
  endtask : acc
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      rc(ra(c, 8'h00), 32'h00000000);
      rc(ra(c, 8'h04), 32'h01010101);
      rc(ra(c, 8'h08), 32'h00030003);
      rc(ra(c, 8'h0c), 32'h10001000);
    end
    rc(8'h80, 32'h0);
    chk("pslverr", 32'h1, {31'h0, ev});
    wr(ra(3, 8'h00), 32'hffffffff);
    rc(ra(3, 8'h00), 32'h3f3f3f3f);
    wr(ra(3, 8'h04), 32'hffffffff);
    rc(ra(3, 8'h04), 32'h7f7f7f7f);
    $display("test register map done");
    // staged timing, then committed by the mode write
    wr(ra(1, 8'h00), 32'h02010301);
    wr(ra(1, 8'h04), 32'h04030201);
    wr(ra(1, 8'h08), 32'h00080006);
    acc(1'b0, 3'd1, 26'h0000123);
    chk("staged cs low", 32'd1, 32'(nlo));
    wr(ra(1, 8'h0c), md(1'b0, 2'h0, 2'h0, 1'b0));
    acc(1'b0, 3'd1, 26'h0000123);
    chk("read latency", 32'd8, 32'(lat));
    chk("read no write strobe", 32'd0, 32'(wlo));
    chk("read cs start", 32'd3, 32'(lo1));
    chk("read cs width", 32'd4, 32'(nlo));
    acc(1'b1, 3'd1, 26'h0000124);
    chk("write cs start", 32'd4, 32'(lo1));
    chk("write cs width", 32'd2, 32'(nlo));
    chk("write strobe width", 32'd1, 32'(wlo));
    chk("write data enable", 32'd6, 32'(noe));
    chk("write data", 32'h0badf00d, wd);
    wr(ra(2, 8'h00), 32'h21000000);
    wr(ra(2, 8'h04), 32'h41010101);
    wr(ra(2, 8'h08), 32'h01000003);
    wr(ra(2, 8'h0c), 32'h0);
    acc(1'b0, 3'd2, 26'h0000200);
    chk("long cs start", 32'd130, 32'(lo1));
    chk("long cs width", 32'd257, 32'(nlo));
    $display("test standard timing done");
    // page mode; read setups and cycle deliberately misleading
    wr(ra(4, 8'h00), 32'h1f1f0000);
    wr(ra(4, 8'h04), 32'h05020101);
    wr(ra(4, 8'h08), 32'h00020002);
    for (int p = 0; p < 4; p++) begin
      wr(ra(4, 8'h0c), md(1'b1, 2'(p), 2'h0, 1'b0));
      a = 26'((p + 1) * 256);
      sz = 4 << p;
      acc(1'b0, 3'd4, a + 26'h1);
      chk("first access", 32'd5, 32'(lat));
      chk("page data", {~a[5:0] ^ 6'h01, a + 26'h1}, rv);
      chk("strobe vs cs", 32'd0, 32'(dif));
      acc(1'b0, 3'd4, a + 26'(sz - 1));
      chk("page hit", 32'd2, 32'(lat));
      chk("strobe vs cs", 32'd0, 32'(dif));
      acc(1'b0, 3'd4, a + 26'(sz));
      chk("next page", 32'd5, 32'(lat));
    end
    wr(ra(5, 8'h04), 32'h05020101);
    wr(ra(5, 8'h0c), md(1'b1, 2'h1, 2'h0, 1'b0));
    acc(1'b0, 3'd4, 26'h0000400);
    acc(1'b0, 3'd5, 26'h0000400);
    chk("other cs", 32'd5, 32'(lat));
    acc(1'b0, 3'd4, 26'h0000401);
    chk("after other access", 32'd5, 32'(lat));
    acc(1'b0, 3'd4, 26'h0000402);
    chk("hit again", 32'd2, 32'(lat));
    wr(ra(4, 8'h04), 32'h01040101);
    wr(ra(4, 8'h0c), md(1'b1, 2'h1, 2'h0, 1'b0));
    acc(1'b0, 3'd4, 26'h0000500);
    chk("short first", 32'd1, 32'(lat));
    acc(1'b0, 3'd4, 26'h0000501);
    chk("long hit", 32'd4, 32'(lat));
    $display("test page mode done");
    for (int i = 0; i < 3; i++) begin
      wr(ra(6, 8'h0c), md(1'b1, 2'h3, i == 1 ? 2'h1 : 2'h2, i == 2));
      a = 26'h607 + 26'(i * 256);
      acc(1'b0, 3'd6, a);
      chk("mem addr", {6'h0, a[25:2], i == 1 ? a[1] : 1'b0, 1'b0},
        {6'h0, ma});
      chk("byte select", {28'h0, i == 2 ? 4'hf : 4'ha}, {28'h0, bs});
    end
    $display("test width and byte select done");
    give_verdict();
  end
endmodule : test_static_mem_page_mode_timing
